//--- pkg/dgr_defs.svh
// Constants for the gear-down and refresh command front end
`ifndef DGR_DEFS_SVH
`define DGR_DEFS_SVH

// Gear-down mode register select: mode register 3, bit A3
`define DGR_MR_GEAR_BA 2'h3
`define DGR_MR_GEAR_BG 1'h0

// Control lines are sampled on this phase while in 2N mode
`define DGR_PHASE_CTL 1'h0

// Command gear delay, in link clock periods
`define DGR_CMD_GEAR_NCK 8'h08

// Minimum refresh cycle time in ns and core clock rate in MHz
`define DGR_TRFC_NS 350
`define DGR_CORE_CLK_MHZ 20
// Least time, so round up to whole core cycles
`define DGR_TRFC_CYC ((`DGR_TRFC_NS * `DGR_CORE_CLK_MHZ + 999) / 1000)

// Reset values
`define DGR_ROW_RST 16'h0000
`define DGR_WINDOW_RST 1'h1

`endif

//--- pkg/dgr_pkg.sv
// Types for the gear-down and refresh command front end
package dgr_pkg;

    // Control gear state, one-hot
    typedef enum logic [3:0] {
        GEAR_1N = 4'h1,
        GEAR_WAIT_SYNC = 4'h2,
        GEAR_DLY = 4'h4,
        GEAR_2N = 4'h8
    } dgr_gear_state_t;

endpackage

//--- design/dgr_sync.sv
// Two-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
module dgr_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Levels in and out
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_reg;

    // First flop feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule

//--- design/dgr_cycle_timer.sv
// Loadable down counter that reports busy and a done pulse
`timescale 1ns/1ps
module dgr_cycle_timer #(
    parameter int CNT_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Start
    input wire logic load,
    input wire logic [CNT_W-1:0] load_val,
    // Status
    output logic busy,
    output logic done
);

    localparam logic [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};

    logic [CNT_W-1:0] cnt_reg;

    // Count down to zero after a load
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else if (load) begin
            cnt_reg <= load_val;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - ONE;
        end
    end

    // Busy level and one-cycle done
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            busy <= load ? (load_val != '0) : (cnt_reg > ONE);
            done <= !load && (cnt_reg == ONE);
        end
    end

endmodule

//--- design/dgr_top.sv
// Gear-down (1N/2N) control and refresh command front end of the device
`timescale 1ns/1ps
`include "dgr_defs.svh"
module dgr_top #(
    parameter int GEAR_W = 8,
    parameter logic [GEAR_W-1:0] CMD_GEAR_NCK = `DGR_CMD_GEAR_NCK,
    parameter int ROW_W = 16,
    parameter int RFC_W = 8
) (
    // Core clock and reset
    core_clk,
    resetn,
    // Link clock and command pins, driven by the controller
    link_ck,
    cke,
    cs_n,
    act_n,
    ras_n_a16,
    cas_n_a15,
    we_n_a14,
    ba,
    bg,
    addr_a3,
    // Link domain status
    gear_state_ck,
    ctl_phase_ck,
    cmd_ref_ck,
    cmd_mrs_ck,
    // Core domain status
    gear_2n,
    gear_ready,
    self_refresh,
    refresh_row,
    banks_idle
);
    import dgr_pkg::*;

    // Core clock and reset
    input wire logic core_clk;
    input wire logic resetn;
    // Link clock and command pins
    input wire logic link_ck;
    input wire logic cke;
    input wire logic cs_n;
    input wire logic act_n;
    input wire logic ras_n_a16;
    input wire logic cas_n_a15;
    input wire logic we_n_a14;
    input wire logic [1:0] ba;
    input wire logic bg;
    input wire logic addr_a3;
    // Link domain status
    output dgr_pkg::dgr_gear_state_t gear_state_ck;
    output logic ctl_phase_ck;
    output logic cmd_ref_ck;
    output logic cmd_mrs_ck;
    // Core domain status
    output logic gear_2n;
    output logic gear_ready;
    output logic self_refresh;
    output logic [ROW_W-1:0] refresh_row;
    output logic banks_idle;

    // Link domain
    logic rst_ck_n;
    dgr_gear_state_t state_reg;
    logic phase_reg;
    logic parity_reg;
    logic gear_2n_reg;
    logic gear_ready_reg;
    logic self_ref_reg;
    logic cke_s_reg;
    logic window_reg;
    logic ref_tgl_reg;
    logic gear_done;
    logic ctl_edge;
    logic cs_ok;
    logic enc_ref;
    logic enc_mrs;
    logic enc_nop;
    logic ref_hit;
    logic sre_hit;
    logic srx_hit;
    logic mrs_hit;
    logic nop_hit;
    logic gear_mrs;
    logic other_hit;
    logic sync_hit;

    // Reset release aligned to the link clock
    dgr_sync #(.WIDTH(1)) u_rst_ck (
        .clk(link_ck),
        .rst_n(resetn),
        .d(1'b1),
        .q(rst_ck_n)
    );

    // Control lines are taken every clock in 1N, every other in 2N
    assign ctl_edge = !gear_2n_reg || (phase_reg == `DGR_PHASE_CTL);
    assign cs_ok = ctl_edge && !cs_n;

    // Command encodings with ACT high; address pins are ignored
    assign enc_ref = act_n && !ras_n_a16 && !cas_n_a15 && we_n_a14;
    assign enc_mrs = act_n && !ras_n_a16 && !cas_n_a15 && !we_n_a14;
    assign enc_nop = act_n && ras_n_a16 && cas_n_a15 && we_n_a14;

    // Decoded events on the link
    assign ref_hit = cs_ok && enc_ref && cke_s_reg && cke
        && !self_ref_reg;
    assign sre_hit = cs_ok && enc_ref && cke_s_reg && !cke
        && !self_ref_reg;
    assign srx_hit = ctl_edge && self_ref_reg && cke;
    assign mrs_hit = cs_ok && enc_mrs && cke && !self_ref_reg;
    assign nop_hit = cs_ok && enc_nop && cke && !self_ref_reg;
    assign other_hit = cs_ok && cke && !self_ref_reg
        && !enc_ref && !enc_mrs && !enc_nop;
    assign gear_mrs = mrs_hit && (ba == `DGR_MR_GEAR_BA)
        && (bg == `DGR_MR_GEAR_BG) && addr_a3;
    // Sync pulse only counts on an even clock from the gear write
    assign sync_hit = nop_hit && (state_reg == GEAR_WAIT_SYNC)
        && !parity_reg;

    // CKE as last sampled on a control edge
    always_ff @(posedge link_ck or negedge rst_ck_n) begin
        if (!rst_ck_n) begin
            cke_s_reg <= 1'b0;
        end else if (ctl_edge) begin
            cke_s_reg <= cke;
        end
    end

    // Self refresh entry and exit
    always_ff @(posedge link_ck or negedge rst_ck_n) begin
        if (!rst_ck_n) begin
            self_ref_reg <= 1'b0;
        end else if (sre_hit) begin
            self_ref_reg <= 1'b1;
        end else if (srx_hit) begin
            self_ref_reg <= 1'b0;
        end
    end

    // Gear-down window: open from reset and on self refresh exit
    always_ff @(posedge link_ck or negedge rst_ck_n) begin
        if (!rst_ck_n) begin
            window_reg <= `DGR_WINDOW_RST;
        end else if (srx_hit) begin
            window_reg <= 1'b1;
        end else if (other_hit) begin
            window_reg <= 1'b0;
        end
    end

    // Gear state machine
    always_ff @(posedge link_ck or negedge rst_ck_n) begin
        if (!rst_ck_n) begin
            state_reg <= GEAR_1N;
        end else begin
            case (state_reg)
                GEAR_1N: begin
                    if (gear_mrs && window_reg) begin
                        state_reg <= GEAR_WAIT_SYNC;
                    end
                end
                GEAR_WAIT_SYNC: begin
                    if (sre_hit) begin
                        state_reg <= GEAR_1N;
                    end else if (sync_hit) begin
                        state_reg <= GEAR_DLY;
                    end
                end
                GEAR_DLY: begin
                    if (sre_hit) begin
                        state_reg <= GEAR_1N;
                    end else if (gear_done) begin
                        state_reg <= GEAR_2N;
                    end
                end
                GEAR_2N: begin
                    if (sre_hit) begin
                        state_reg <= GEAR_1N;
                    end
                end
                default: begin
                    state_reg <= GEAR_1N;
                end
            endcase
        end
    end

    // Clock parity since the gear write, even means zero
    always_ff @(posedge link_ck or negedge rst_ck_n) begin
        if (!rst_ck_n) begin
            parity_reg <= 1'b1;
        end else if (state_reg != GEAR_WAIT_SYNC) begin
            parity_reg <= 1'b1;
        end else begin
            parity_reg <= ~parity_reg;
        end
    end

    // Sampling phase, realigned by the sync pulse
    always_ff @(posedge link_ck or negedge rst_ck_n) begin
        if (!rst_ck_n) begin
            phase_reg <= 1'b0;
        end else if (sync_hit) begin
            phase_reg <= ~`DGR_PHASE_CTL;
        end else begin
            phase_reg <= ~phase_reg;
        end
    end

    // Command gear delay after the sync pulse
    dgr_cycle_timer #(.CNT_W(GEAR_W)) u_gear_tmr (
        .clk(link_ck),
        .rst_n(rst_ck_n),
        .load(sync_hit),
        .load_val(CMD_GEAR_NCK),
        .busy(),
        .done(gear_done)
    );

    // 2N sampling from sync; ready once the gear delay is over
    always_ff @(posedge link_ck or negedge rst_ck_n) begin
        if (!rst_ck_n) begin
            gear_2n_reg <= 1'b0;
            gear_ready_reg <= 1'b0;
        end else if (sre_hit) begin
            gear_2n_reg <= 1'b0;
            gear_ready_reg <= 1'b0;
        end else begin
            if (sync_hit) begin
                gear_2n_reg <= 1'b1;
            end
            if (gear_done && (state_reg == GEAR_DLY)) begin
                gear_ready_reg <= 1'b1;
            end
        end
    end

    // Link status and the refresh event toggle toward the core
    always_ff @(posedge link_ck or negedge rst_ck_n) begin
        if (!rst_ck_n) begin
            cmd_ref_ck <= 1'b0;
            cmd_mrs_ck <= 1'b0;
            ref_tgl_reg <= 1'b0;
        end else begin
            cmd_ref_ck <= ref_hit;
            cmd_mrs_ck <= mrs_hit;
            ref_tgl_reg <= ref_tgl_reg ^ ref_hit;
        end
    end

    assign gear_state_ck = state_reg;
    assign ctl_phase_ck = phase_reg;

    // Core domain
    logic [3:0] sync_q;
    logic ref_seen_reg;
    logic ref_pulse;
    logic rfc_done;

    // Levels and the refresh toggle cross into the core clock
    dgr_sync #(.WIDTH(4)) u_cross (
        .clk(core_clk),
        .rst_n(resetn),
        .d({ref_tgl_reg, gear_2n_reg, gear_ready_reg, self_ref_reg}),
        .q(sync_q)
    );

    assign ref_pulse = sync_q[3] ^ ref_seen_reg;

    // Gear and self refresh status registered for the outputs
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ref_seen_reg <= 1'b0;
            gear_2n <= 1'b0;
            gear_ready <= 1'b0;
            self_refresh <= 1'b0;
        end else begin
            ref_seen_reg <= sync_q[3];
            gear_2n <= sync_q[2];
            gear_ready <= sync_q[1];
            self_refresh <= sync_q[0];
        end
    end

    // Internal refresh row counter
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            refresh_row <= `DGR_ROW_RST;
        end else if (ref_pulse) begin
            refresh_row <= refresh_row + 1'b1;
        end
    end

    // Refresh cycle timing in core cycles
    dgr_cycle_timer #(.CNT_W(RFC_W)) u_rfc_tmr (
        .clk(core_clk),
        .rst_n(resetn),
        .load(ref_pulse),
        .load_val(RFC_W'(`DGR_TRFC_CYC)),
        .busy(),
        .done(rfc_done)
    );

    // Banks busy during refresh, precharged idle once it completes
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            banks_idle <= 1'b1;
        end else if (ref_pulse) begin
            banks_idle <= 1'b0;
        end else if (rfc_done) begin
            banks_idle <= 1'b1;
        end
    end

    // Assertions
    sequence s_gear_end;
        (state_reg == GEAR_DLY) && gear_done && !sre_hit;
    endsequence

    sequence s_ref_quiet;
        ref_pulse ##1 (!ref_pulse [*8]);
    endsequence

    a_gear_window: assert property (
        @(posedge link_ck) disable iff (!rst_ck_n)
        (state_reg == GEAR_1N && gear_mrs && !window_reg)
        |=> (state_reg == GEAR_1N))
        else $error("gear write honoured outside its window");

    a_no_2n_unsynced: assert property (
        @(posedge link_ck) disable iff (!rst_ck_n)
        $rose(gear_2n_reg) |-> $past(state_reg == GEAR_WAIT_SYNC)
        && $past(nop_hit) && !$past(parity_reg))
        else $error("2N entered without an even sync pulse");

    a_2n_odd_ignored: assert property (
        @(posedge link_ck) disable iff (!rst_ck_n)
        (gear_2n_reg && phase_reg != `DGR_PHASE_CTL) |=> !cmd_ref_ck)
        else $error("command taken on an off phase in 2N");

    a_gear_delay: assert property (
        @(posedge link_ck) disable iff (!rst_ck_n)
        s_gear_end |=> (state_reg == GEAR_2N) && gear_ready_reg)
        else $error("2N not ready after the command gear delay");

    a_sr_reverts: assert property (
        @(posedge link_ck) disable iff (!rst_ck_n)
        sre_hit |=> (state_reg == GEAR_1N) && !gear_2n_reg
        && self_ref_reg)
        else $error("self refresh did not restore 1N");

    a_ref_decode: assert property (
        @(posedge link_ck) disable iff (!rst_ck_n)
        (!gear_2n_reg && !self_ref_reg && cke_s_reg && cke && !cs_n
        && !ras_n_a16 && !cas_n_a15 && we_n_a14 && act_n)
        |=> cmd_ref_ck && $changed(ref_tgl_reg))
        else $error("refresh command not decoded");

    a_row_step: assert property (
        @(posedge core_clk) disable iff (!resetn)
        ref_pulse |=> (refresh_row == $past(refresh_row) + 1'b1))
        else $error("refresh row did not advance");

    a_banks_idle: assert property (
        @(posedge core_clk) disable iff (!resetn)
        s_ref_quiet |=> banks_idle)
        else $error("banks not idle after the refresh cycle");

endmodule

//--- tb/dgr_ctl_model.sv
// Controller-side model: free-running link clock and command pin driver
`timescale 1ns/1ps
module dgr_ctl_model (
    // Link clock
    output logic link_ck,
    // Command pins
    output logic cke,
    output logic cs_n,
    output logic act_n,
    output logic ras_n_a16,
    output logic cas_n_a15,
    output logic we_n_a14,
    // Address pins
    output logic [1:0] ba,
    output logic bg,
    output logic addr_a3
);
    // Link clock runs free, phase offset from the core clock
    initial begin
        link_ck = 1'b0;
        #37;
        forever #80 link_ck = ~link_ck;
    end

    // Pins start deselected with the clock enable high
    initial begin
        {cke, cs_n, act_n, ras_n_a16, cas_n_a15, we_n_a14} = 6'h3f;
        {ba, bg, addr_a3} = 4'h0;
    end

    // Hold one command static for n link edges, then settle
    task automatic send(input logic [5:0] c, input logic [3:0] adr,
                        input int n);
        {cke, cs_n, act_n, ras_n_a16, cas_n_a15, we_n_a14} = c;
        {ba, bg, addr_a3} = adr;
        repeat (n) @(posedge link_ck);
        #2;
    endtask

    // Drop the select; released address lines no longer hold their value
    task automatic release_bus();
        cs_n = 1'b1;
        {ba, bg, addr_a3} = ~{ba, bg, addr_a3};
    endtask

    // Deselect for n edges with the address toggling each cycle
    task automatic des(input int n);
        repeat (n) begin
            release_bus();
            @(posedge link_ck);
            #2;
        end
    endtask
endmodule

//--- tb/dgr_geardown_refresh_control_bench.sv
// Self-checking bench for the gear-down and refresh front end
`timescale 1ns/1ps
`include "dgr_defs.svh"
module dgr_geardown_refresh_control_bench;
    import dgr_pkg::*;
    localparam logic [7:0] NCK = 8'h04;
    // Commands as {cke, cs_n, act_n, ras_n, cas_n, we_n}
    localparam logic [5:0] C_DES = 6'h3f;
    localparam logic [5:0] C_NOP = 6'h2f;
    localparam logic [5:0] C_REF = 6'h29;
    localparam logic [5:0] C_MRS = 6'h28;
    localparam logic [5:0] C_SRE = 6'h09;
    // Near misses of refresh: deselect, activate, ras high, cas high, mrs
    localparam logic [29:0] MISS = {6'h3f, 6'h21, 6'h2d, 6'h2b, 6'h28};
    localparam logic [3:0] A_GEAR = 4'hd; // Bank 3, group 0, A3 set
    logic core_clk, resetn, link_ck, cke, cs_n, act_n, ras_n_a16;
    logic cas_n_a15, we_n_a14, bg, addr_a3;
    logic [1:0] ba;
    dgr_gear_state_t gear_state_ck;
    logic ctl_phase_ck, cmd_ref_ck, cmd_mrs_ck, gear_2n, gear_ready;
    logic self_refresh, banks_idle;
    logic [15:0] refresh_row;
    int fails, cmp_count, ref_seen, mrs_seen, exp_ref, exp_mrs, exp_row, i;
    integer seed;

    dgr_ctl_model u_ctl (.link_ck(link_ck), .cke(cke), .cs_n(cs_n),
        .act_n(act_n), .ras_n_a16(ras_n_a16), .cas_n_a15(cas_n_a15),
        .we_n_a14(we_n_a14), .ba(ba), .bg(bg), .addr_a3(addr_a3));

    dgr_top #(.CMD_GEAR_NCK(NCK)) dut (.core_clk(core_clk),
        .resetn(resetn), .link_ck(link_ck), .cke(cke), .cs_n(cs_n),
        .act_n(act_n), .ras_n_a16(ras_n_a16), .cas_n_a15(cas_n_a15),
        .we_n_a14(we_n_a14), .ba(ba), .bg(bg), .addr_a3(addr_a3),
        .gear_state_ck(gear_state_ck), .ctl_phase_ck(ctl_phase_ck),
        .cmd_ref_ck(cmd_ref_ck), .cmd_mrs_ck(cmd_mrs_ck),
        .gear_2n(gear_2n), .gear_ready(gear_ready),
        .self_refresh(self_refresh), .refresh_row(refresh_row),
        .banks_idle(banks_idle));

    // Core clock, 50 ns period
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Count decoded command pulses
    always @(posedge link_ck) begin
        if (cmd_ref_ck === 1'b1) ref_seen++;
        if (cmd_mrs_ck === 1'b1) mrs_seen++;
    end

    // Random address nibble for commands that ignore the address
    function automatic logic [3:0] rnd_adr();
        logic [31:0] r;
        r = $random(seed);
        return r[3:0];
    endfunction

    task automatic chk_num(input logic [31:0] got, input logic [31:0] exp,
                           input string what);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %0h want %0h", $time, what,
                     got, exp);
        end
    endtask

    task automatic chk_state(input dgr_gear_state_t exp);
        cmp_count++;
        if (gear_state_ck !== exp) begin
            fails++;
            $display("unexpected at %0t: gear state %0h want %0h", $time,
                     gear_state_ck, exp);
        end
    endtask

    task report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Bounded wait on a core status level, then realign to the link clock
    task automatic wait_core(input int sel, input logic v);
        logic s;
        for (int k = 0; k < 200; k++) begin
            @(posedge core_clk);
            #1;
            case (sel)
                0: s = gear_2n;
                1: s = gear_ready;
                default: s = self_refresh;
            endcase
            if (s === v) break;
        end
        chk_num(s, v, "core status level");
        if (s !== v) report_and_stop();
        @(posedge link_ck);
        #2;
    endtask

    // Pulse and row counts against the model
    task automatic check_counts();
        u_ctl.des(2);
        chk_num(ref_seen, exp_ref, "refresh pulses");
        chk_num(mrs_seen, exp_mrs, "mode write pulses");
        chk_num(refresh_row, exp_row[15:0], "refresh row");
    endtask

    // One refresh with a random address; optionally time the busy window
    task automatic do_ref(input int n, input bit timed);
        logic [31:0] r;
        int k;
        r = $random(seed);
        u_ctl.send(C_REF, r[3:0], n);
        exp_ref++;
        exp_row++;
        if (timed) begin
            u_ctl.release_bus();
            k = 0;
            while (banks_idle !== 1'b0 && k < 20) begin
                @(posedge core_clk);
                #1;
                k++;
            end
            k = 0;
            while (banks_idle !== 1'b1 && k < 100) begin
                @(posedge core_clk);
                #1;
                k++;
            end
            chk_num(k >= `DGR_TRFC_CYC, 1, "refresh busy time");
            chk_num(banks_idle, 1, "banks idle after refresh");
            @(posedge link_ck);
            #2;
        end
        u_ctl.des(3);
    endtask

    // Gear write, odd sync refused, even sync taken, then command gear delay
    task automatic gear_entry();
        int k;
        u_ctl.send(C_MRS, A_GEAR, 1);
        exp_mrs++;
        chk_state(GEAR_WAIT_SYNC);
        u_ctl.send(C_DES, A_GEAR, 2);
        u_ctl.send(C_NOP, rnd_adr(), 1);
        chk_state(GEAR_WAIT_SYNC);
        u_ctl.send(C_NOP, rnd_adr(), 1);
        chk_state(GEAR_DLY);
        k = 0;
        while (gear_state_ck !== GEAR_2N && k < 40) begin
            u_ctl.des(1);
            k++;
        end
        // Gear delay plus the registered done of the delay timer
        chk_num(k, NCK + 8'h01, "command gear delay");
        wait_core(0, 1'b1);
        wait_core(1, 1'b1);
    endtask

    // Watchdog against a hang
    initial begin
        #400000;
        fails++;
        $display("unexpected at %0t: run timed out", $time);
        report_and_stop();
    end

    initial begin
        resetn = 1'b0;
        seed = 32'h0fd2983b;
        {fails, cmp_count, ref_seen, mrs_seen} = '0;
        {exp_ref, exp_mrs, exp_row} = '0;
        repeat (4) @(posedge core_clk);
        repeat (3) @(posedge link_ck);
        @(posedge core_clk);
        chk_state(GEAR_1N);
        chk_num({banks_idle, gear_2n, gear_ready, self_refresh, ctl_phase_ck},
                32'h10, "status at reset");
        chk_num(refresh_row, 0, "row at reset");
        #2 resetn = 1'b1;
        repeat (4) @(posedge link_ck);
        #2;
        // Refresh in 1N with no gear write, then back to back
        do_ref(1, 1'b1);
        for (i = 0; i < 3; i++) do_ref(1, 1'b0);
        check_counts();
        chk_state(GEAR_1N);
        $display("test 1 refresh in 1N done");
        // Near-miss decodes, then a gear write with the window closed
        for (i = 0; i < 5; i++) begin
            u_ctl.send(MISS[6*i +: 6], rnd_adr() & 4'he, 1);
            u_ctl.des(1);
        end
        exp_mrs++;
        check_counts();
        u_ctl.send(C_MRS, A_GEAR, 1);
        exp_mrs++;
        u_ctl.des(3);
        u_ctl.send(C_NOP, rnd_adr(), 1);
        u_ctl.des(2);
        chk_state(GEAR_1N);
        $display("test 2 decode and closed window done");
        // Self refresh from 1N reopens the window
        u_ctl.send(C_SRE, rnd_adr(), 1);
        u_ctl.des(2);
        wait_core(2, 1'b1);
        u_ctl.send(C_DES, rnd_adr(), 1);
        wait_core(2, 1'b0);
        u_ctl.des(4);
        do_ref(1, 1'b0);
        gear_entry();
        check_counts();
        $display("test 3 gear entry after self refresh done");
        // In 2N a refresh held two clocks is taken once
        do_ref(2, 1'b0);
        u_ctl.send(C_MRS, 4'hc, 2);
        exp_mrs++;
        u_ctl.des(2);
        chk_state(GEAR_2N);
        check_counts();
        $display("test 4 2N sampling done");
        // Self refresh from 2N restores 1N
        u_ctl.send(C_SRE, rnd_adr(), 2);
        chk_state(GEAR_1N);
        wait_core(0, 1'b0);
        u_ctl.send(C_DES, rnd_adr(), 1);
        wait_core(2, 1'b0);
        u_ctl.des(4);
        do_ref(1, 1'b1);
        check_counts();
        chk_state(GEAR_1N);
        $display("test 5 self refresh back to 1N done");
        report_and_stop();
    end
endmodule
